// ---- common/srg_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the rate generator block.
// Assumes inclusion by the package and the design modules, by its bare name.
// Summary of operation
// - Transmit pin status shows driven output level
// - Receive pin status shows input pin level when RXGP is set, else 0
// - Frame sync polarity: 0 high, 1 low
// - Transmit clock polarity: 0 rising, 1 falling
// - Receive clock polarity: 0 falling, 1 rising
// - Reference clock: external, CPU, receive, transmit
// - Source needs both pin and generator bits
// - Resync only with external pin; else free
// - Resync: frame sync follows receive frame sync
// - Resync ignores programmed frame period
// - External edge select: 0 rising, 1 falling
// - Mode 0: frame sync on data copy
// - Mode 1: frame sync from generator
// - Frame period field gives 1 to 4096
// - Source mode: internal when 1, external 0
// - Extended select: 0 ext/CPU, 1 pins
`ifndef SRG_CFG_SVH
`define SRG_CFG_SVH
// Subaddresses of the two registers
`define SRG_SUB_RATE_GENERATOR_CONTROL_TWO 8'h07
`define SRG_SUB_PCR 8'h0e
// Pin control register fields
`define SRG_PCR_TXGP 13
`define SRG_PCR_RXGP 12
`define SRG_PCR_TX_SYNC_SOURCE_MODE 11
`define SRG_PCR_REF_CLOCK_EXT_SELECT 7
`define SRG_PCR_TXLVL 5
`define SRG_PCR_RXLVL 4
`define SRG_PCR_TX_SYNC_POLARITY 3
`define SRG_PCR_RX_SYNC_POLARITY 2
`define SRG_PCR_TX_CLOCK_POLARITY 1
`define SRG_PCR_RX_CLOCK_POLARITY 0
`define SRG_PCR_WMASK 16'h3faf
`define SRG_PCR_RESET 16'h0000
// Generator control register two fields
`define SRG_G_GEN_RESYNC_ENABLE 15
`define SRG_G_EXT_REF_EDGE_SELECT 14
`define SRG_G_REF_CLOCK_SELECT 13
`define SRG_G_GEN_TX_SYNC_MODE 12
`define SRG_G_FRAME_PERIOD_W 12
`define SRG_G_RESET 16'h0000
// Reference ticks per half period of the generated bit clock
`define SRG_HALF_TICKS 1
`endif

// ---- common/srg_pkg.sv ----
// Types shared by the rate generator modules.
// Assumes srg_cfg.svh is on the include path.
package srg_pkg;
  `include "srg_cfg.svh"
  typedef logic [15:0] srg_word_t;
  typedef logic [`SRG_G_FRAME_PERIOD_W-1:0] srg_frame_period_t;
  // Pin vector order of the synchroniser
  typedef enum logic [2:0] {
    SRG_PIN_EXT = 3'h0,
    SRG_PIN_RXC = 3'h1,
    SRG_PIN_TXC = 3'h2,
    SRG_PIN_RXF = 3'h3,
    SRG_PIN_RXD = 3'h4
  } srg_pin_t;
endpackage

// ---- design/srg_pin_sync.sv ----
// Two-flop synchroniser with edge detection for a vector of pins.
// Assumes asynchronous pins and the block's single clock.
module srg_pin_sync #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw pins and clean results
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] level_out,
  output logic [N-1:0] rise_out,
  output logic [N-1:0] fall_out
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
      // Next stage values; the first flop feeds only the second
      always_comb begin
        s1_d = rst_n_in ? pin_in[i] : 1'b0;
        s2_d = rst_n_in ? s1_q : 1'b0;
        s3_d = rst_n_in ? s2_q : 1'b0;
      end
      // Stage registers
      always_ff @(posedge clk_in) begin
        s1_q <= s1_d;
        s2_q <= s2_d;
        s3_q <= s3_d;
      end
      assign level_out[i] = s2_q;
      assign rise_out[i] = s2_q & ~s3_q;
      assign fall_out[i] = ~s2_q & s3_q;
    end
  endgenerate
endmodule

// ---- design/srg_rate_gen.sv ----
// Sample rate generator, frame sync generation and pin polarity/status logic.
// Assumes register accesses by subaddress on the block clock and asynchronous serial pins.
`include "srg_cfg.svh"
module srg_rate_gen #(
  parameter int HALF_TICKS = `SRG_HALF_TICKS
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // Subbank register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire srg_pkg::srg_word_t REG_WDATA_IN,
  output srg_pkg::srg_word_t REG_RDATA_OUT,
  // Serial pins
  input wire logic EXT_REF_CLOCK_PIN_IN,
  input wire logic RX_CLOCK_PIN_IN,
  input wire logic TX_CLOCK_PIN_IN,
  input wire logic RX_FRAME_SYNC_IN,
  input wire logic RX_DATA_PIN_IN,
  output logic TX_DATA_PIN_OUT,
  output logic TX_FRAME_SYNC_OUT,
  output logic TX_FRAME_SYNC_OE_OUT,
  // Shift logic side
  input wire logic TX_SER_DATA_IN,
  input wire logic TX_COPY_IN,
  output logic GENERATED_BIT_CLOCK_OUT,
  output logic GENERATED_FRAME_SYNC_OUT,
  output logic TX_SHIFT_EDGE_OUT,
  output logic RX_SAMPLE_EDGE_OUT,
  output logic RX_FRAME_START_OUT
);
  import srg_pkg::*;

  localparam int HW = (HALF_TICKS > 1) ? $clog2(HALF_TICKS) : 1;

  logic [4:0] lvl, rise, fall;
  srg_word_t pcr_q, pcr_d, gen_q, gen_d, rdata_q, rdata_d;
  logic [HW-1:0] half_q, half_d;
  srg_frame_period_t frm_q, frm_d;
  logic generated_bit_clock_q, generated_bit_clock_d, fsg_q, fsg_d, pend_q, pend_d;
  logic copy_q, copy_d, cfs_q, cfs_d;
  logic dx_q, dx_d, fsx_q, fsx_d, fsxoe_q, fsxoe_d;
  logic txe_q, txe_d, rxe_q, rxe_d, rxs_q, rxs_d;
  logic ref_tick, half_end, bit_tick, resync, fsr_start, fsx_act;

  srg_pin_sync #(.N(5)) u_sync (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .pin_in({RX_DATA_PIN_IN, RX_FRAME_SYNC_IN, TX_CLOCK_PIN_IN, RX_CLOCK_PIN_IN,
             EXT_REF_CLOCK_PIN_IN}),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  // Reference tick: the pin bit and the generator bit together pick it
  always_comb begin
    case ({pcr_q[`SRG_PCR_REF_CLOCK_EXT_SELECT], gen_q[`SRG_G_REF_CLOCK_SELECT]})
      2'b00: ref_tick = gen_q[`SRG_G_EXT_REF_EDGE_SELECT] ? fall[SRG_PIN_EXT] : rise[SRG_PIN_EXT];
      2'b01: ref_tick = 1'b1;
      2'b10: ref_tick = rise[SRG_PIN_RXC];
      2'b11: ref_tick = rise[SRG_PIN_TXC];
      default: ref_tick = 1'b0;
    endcase
  end

  // Resync is only meaningful with the external pin as reference
  assign resync = gen_q[`SRG_G_GEN_RESYNC_ENABLE] & ~pcr_q[`SRG_PCR_REF_CLOCK_EXT_SELECT]
                  & ~gen_q[`SRG_G_REF_CLOCK_SELECT];
  // Receive frame sync leading edge, polarity applied
  assign fsr_start = pcr_q[`SRG_PCR_RX_SYNC_POLARITY] ? fall[SRG_PIN_RXF] : rise[SRG_PIN_RXF];
  assign half_end = ref_tick & (half_q == HW'(HALF_TICKS - 1));
  assign bit_tick = half_end & ~generated_bit_clock_q;

  // Register file: writes and registered reads
  always_comb begin
    pcr_d = pcr_q;
    gen_d = gen_q;
    rdata_d = rdata_q;
    if (REG_WR_IN && REG_ADDR_IN == `SRG_SUB_PCR) begin
      pcr_d = REG_WDATA_IN & `SRG_PCR_WMASK;
    end
    if (REG_WR_IN && REG_ADDR_IN == `SRG_SUB_RATE_GENERATOR_CONTROL_TWO) begin
      gen_d = REG_WDATA_IN;
    end
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `SRG_SUB_PCR: begin
          rdata_d = pcr_q;
          rdata_d[`SRG_PCR_TXLVL] = dx_q;
          rdata_d[`SRG_PCR_RXLVL] = pcr_q[`SRG_PCR_RXGP] & lvl[SRG_PIN_RXD];
        end
        `SRG_SUB_RATE_GENERATOR_CONTROL_TWO: rdata_d = gen_q;
        default: rdata_d = 16'h0000;
      endcase
    end
    if (!RST_N_IN) begin
      pcr_d = `SRG_PCR_RESET;
      gen_d = `SRG_G_RESET;
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    pcr_q <= pcr_d;
    gen_q <= gen_d;
    rdata_q <= rdata_d;
  end

  // Bit clock divider and frame counter; resync restarts the divider phase
  always_comb begin
    half_d = half_q;
    generated_bit_clock_d = generated_bit_clock_q;
    frm_d = frm_q;
    fsg_d = fsg_q;
    pend_d = pend_q;
    if (ref_tick) begin
      half_d = half_end ? '0 : half_q + HW'(1);
      generated_bit_clock_d = half_end ? ~generated_bit_clock_q : generated_bit_clock_q;
    end
    if (resync) begin
      if (bit_tick) begin
        fsg_d = pend_q;
        pend_d = 1'b0;
      end
      if (fsr_start) begin
        half_d = '0; // Realign the bit clock to the external frame
        generated_bit_clock_d = 1'b0;
        pend_d = 1'b1;
      end
    end else if (bit_tick) begin
      pend_d = 1'b0;
      if (frm_q == gen_q[`SRG_G_FRAME_PERIOD_W-1:0]) begin
        frm_d = '0;
        fsg_d = 1'b1;
      end else begin
        frm_d = frm_q + 1'b1;
        fsg_d = 1'b0;
      end
    end
    if (!RST_N_IN) begin
      half_d = '0;
      generated_bit_clock_d = 1'b0;
      frm_d = '0;
      fsg_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    half_q <= half_d;
    generated_bit_clock_q <= generated_bit_clock_d;
    frm_q <= frm_d;
    fsg_q <= fsg_d;
    pend_q <= pend_d;
  end

  // Transmit frame sync source; a copy landing with the bit tick is kept, not lost
  assign fsx_act = gen_q[`SRG_G_GEN_TX_SYNC_MODE] ? fsg_q : cfs_q;
  always_comb begin
    copy_d = copy_q;
    cfs_d = cfs_q;
    if (bit_tick) begin
      cfs_d = copy_q;
      copy_d = 1'b0;
    end
    if (TX_COPY_IN) begin
      copy_d = 1'b1;
    end
    fsx_d = fsx_act ^ pcr_q[`SRG_PCR_TX_SYNC_POLARITY];
    fsxoe_d = pcr_q[`SRG_PCR_TX_SYNC_SOURCE_MODE];
    dx_d = pcr_q[`SRG_PCR_TXGP] ? pcr_q[`SRG_PCR_TXLVL] : TX_SER_DATA_IN;
    txe_d = pcr_q[`SRG_PCR_TX_CLOCK_POLARITY] ? fall[SRG_PIN_TXC] : rise[SRG_PIN_TXC];
    rxe_d = pcr_q[`SRG_PCR_RX_CLOCK_POLARITY] ? rise[SRG_PIN_RXC] : fall[SRG_PIN_RXC];
    rxs_d = fsr_start;
    if (!RST_N_IN) begin
      copy_d = 1'b0;
      cfs_d = 1'b0;
      fsx_d = 1'b0;
      fsxoe_d = 1'b0;
      dx_d = 1'b0;
      txe_d = 1'b0;
      rxe_d = 1'b0;
      rxs_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    copy_q <= copy_d;
    cfs_q <= cfs_d;
    fsx_q <= fsx_d;
    fsxoe_q <= fsxoe_d;
    dx_q <= dx_d;
    txe_q <= txe_d;
    rxe_q <= rxe_d;
    rxs_q <= rxs_d;
  end

  // Every output leaves straight from a flop
  assign REG_RDATA_OUT = rdata_q;
  assign TX_DATA_PIN_OUT = dx_q;
  assign TX_FRAME_SYNC_OUT = fsx_q;
  assign TX_FRAME_SYNC_OE_OUT = fsxoe_q;
  assign GENERATED_BIT_CLOCK_OUT = generated_bit_clock_q;
  assign GENERATED_FRAME_SYNC_OUT = fsg_q;
  assign TX_SHIFT_EDGE_OUT = txe_q;
  assign RX_SAMPLE_EDGE_OUT = rxe_q;
  assign RX_FRAME_START_OUT = rxs_q;

  // Checks
  property p_tx_level;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    REG_RD_IN && REG_ADDR_IN == `SRG_SUB_PCR |=> REG_RDATA_OUT[`SRG_PCR_TXLVL] == $past(dx_q);
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("tx level status wrong");

  property p_rx_level;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    REG_RD_IN && REG_ADDR_IN == `SRG_SUB_PCR && !pcr_q[`SRG_PCR_RXGP]
      |=> !REG_RDATA_OUT[`SRG_PCR_RXLVL];
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx level shown outside gp mode");

  property p_fsx_pol;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    ##1 TX_FRAME_SYNC_OUT == ($past(fsx_act) ^ $past(pcr_q[`SRG_PCR_TX_SYNC_POLARITY]));
  endproperty
  a_fsx_pol: assert property (p_fsx_pol) else $error("tx frame sync polarity wrong");

  property p_tx_edge;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    pcr_q[`SRG_PCR_TX_CLOCK_POLARITY] && rise[SRG_PIN_TXC] |=> !TX_SHIFT_EDGE_OUT;
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("tx edge on wrong polarity");

  property p_rx_edge;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !pcr_q[`SRG_PCR_RX_CLOCK_POLARITY] && fall[SRG_PIN_RXC] |=> RX_SAMPLE_EDGE_OUT;
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx sample edge missed");

  property p_pin_src;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    pcr_q[`SRG_PCR_REF_CLOCK_EXT_SELECT] && gen_q[`SRG_G_REF_CLOCK_SELECT] && !rise[SRG_PIN_TXC] |-> !ref_tick;
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("reference tick from wrong source");

  property p_free_frame;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !resync && bit_tick && frm_q == gen_q[`SRG_G_FRAME_PERIOD_W-1:0] |=> fsg_q && frm_q == '0;
  endproperty
  a_free_frame: assert property (p_free_frame) else $error("frame sync not at period");

  property p_resync_wait;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    resync && bit_tick && !pend_q && !fsr_start |=> !fsg_q;
  endproperty
  a_resync_wait: assert property (p_resync_wait) else $error("frame sync without rx sync");

  property p_fsg_width;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !resync && gen_q[`SRG_G_FRAME_PERIOD_W-1:0] != '0 && fsg_q && bit_tick |=> !fsg_q;
  endproperty
  a_fsg_width: assert property (p_fsg_width) else $error("frame sync wider than one bit");
endmodule

// ---- sim/srg_far_side.sv ----
// Far side model: a codec driving the serial clock, sync and data pins.
// Assumes the bench chooses which clock pins run and when a receive sync goes out.
module srg_far_side (
  // Controls from the bench
  input wire logic [2:0] clk_run_in,
  input wire logic sync_req_in,
  input wire logic data_bit_in,
  // Serial pins toward the block
  output logic ext_clk_out,
  output logic rx_clk_out,
  output logic tx_clk_out,
  output logic rx_sync_out,
  output logic rx_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic link_clk = 1'b0;
  // One steady 125 ns source for every pin clock
  always #62.5 link_clk = ~link_clk;
  // Stopped clocks stand low, so a wrong source selection shows no edges
  assign ext_clk_out = link_clk & clk_run_in[0];
  assign rx_clk_out = link_clk & clk_run_in[1];
  assign tx_clk_out = link_clk & clk_run_in[2];
  assign rx_data_out = data_bit_in;
  // Sync pulse one link period wide, launched on a falling link edge; one process drives it
  initial begin
    rx_sync_out = 1'b0;
    forever begin
      @(posedge sync_req_in);
      @(negedge link_clk);
      rx_sync_out = 1'b1;
      @(negedge link_clk);
      rx_sync_out = 1'b0;
    end
  end
endmodule

// ---- sim/srg_rate_gen_test.sv ----
// Self-checking bench for the rate generator, with the codec model on its pins.
// Assumes the package, the design and the far side model are compiled first.
`include "srg_cfg.svh"
module srg_rate_gen_test;
  import srg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam time TD = 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  srg_word_t wdata = 16'h0000;
  srg_word_t rdata;
  logic ext_clk, rx_clk, tx_clk, rx_sync, rx_data, tx_pin, tx_fs, tx_fs_oe;
  logic bit_clk, gen_fs, shift_edge, sample_edge, frame_start;
  logic copy = 1'b0;
  logic sync_req = 1'b0;
  logic data_bit = 1'b0;
  logic [2:0] clk_run = 3'h0;
  int mismatches = 0;
  int checked = 0;
  // Block clock at 125 MHz
  always #4 clk = ~clk;
  srg_rate_gen u_srg_rate_gen (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .EXT_REF_CLOCK_PIN_IN(ext_clk), .RX_CLOCK_PIN_IN(rx_clk), .TX_CLOCK_PIN_IN(tx_clk),
    .RX_FRAME_SYNC_IN(rx_sync), .RX_DATA_PIN_IN(rx_data), .TX_DATA_PIN_OUT(tx_pin),
    .TX_FRAME_SYNC_OUT(tx_fs), .TX_FRAME_SYNC_OE_OUT(tx_fs_oe), .TX_SER_DATA_IN(1'b0),
    .TX_COPY_IN(copy), .GENERATED_BIT_CLOCK_OUT(bit_clk), .GENERATED_FRAME_SYNC_OUT(gen_fs),
    .TX_SHIFT_EDGE_OUT(shift_edge), .RX_SAMPLE_EDGE_OUT(sample_edge),
    .RX_FRAME_START_OUT(frame_start));
  srg_far_side u_srg_far_side (.clk_run_in(clk_run), .sync_req_in(sync_req),
    .data_bit_in(data_bit), .ext_clk_out(ext_clk), .rx_clk_out(rx_clk),
    .tx_clk_out(tx_clk), .rx_sync_out(rx_sync), .rx_data_out(rx_data));
  task automatic cmp(input srg_word_t got, input srg_word_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #TD;
  endtask
  // Strobes stay up until the sampling edge has passed
  task automatic reg_wr(input logic [7:0] a, input srg_word_t d);
    cycles(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cycles(1);
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output srg_word_t d);
    cycles(1);
    addr = a;
    rd = 1'b1;
    cycles(1);
    rd = 1'b0;
    cycles(1);
    d = rdata;
  endtask
  // Settle first, since a source switch may leave one edge in the synchroniser
  task automatic count_toggles(input int n, output int t);
    logic prev;
    cycles(10);
    t = 0;
    prev = bit_clk;
    repeat (n) begin
      cycles(1);
      if (bit_clk !== prev) t++;
      prev = bit_clk;
    end
  endtask
  task automatic count_fs(input int n, output int h);
    cycles(40);
    h = 0;
    repeat (n) begin
      cycles(1);
      if (gen_fs === 1'b1) h++;
    end
  endtask
  task automatic frame_gap(output int gap);
    gap = 0;
    for (int i = 0; i < 9000 && gen_fs !== 1'b1; i++) cycles(1);
    for (int i = 0; i < 9000 && gen_fs === 1'b1; i++) cycles(1);
    while (gap < 9000 && gen_fs !== 1'b1) begin
      gap++;
      cycles(1);
    end
  endtask
  task automatic copy_watch(input logic idle, output int seen);
    seen = 0;
    copy = 1'b1;
    cycles(1);
    copy = 1'b0;
    repeat (12) begin
      cycles(1);
      if (tx_fs === ~idle) seen++;
    end
  endtask
  task automatic t_pin_status();
    srg_word_t d;
    reg_rd(8'h07, d);
    cmp(d, 16'h0000);
    data_bit = 1'b1;
    reg_wr(8'h0e, 16'h2000);
    cycles(6);
    reg_rd(8'h0e, d);
    cmp(d, 16'h2000);
    reg_wr(8'h0e, 16'hffff);
    cycles(6);
    reg_rd(8'h0e, d);
    cmp(d, 16'h3fbf);
    cmp({15'h0000, tx_pin}, 16'h0001);
    data_bit = 1'b0;
    reg_wr(8'h0e, 16'h3000);
    reg_wr(8'h01, 16'hffff);
    cycles(6);
    reg_rd(8'h0e, d);
    cmp(d, 16'h3000);
    reg_rd(8'h01, d);
    cmp(d, 16'h0000);
    $display("test pin_status done");
  endtask
  task automatic t_frame_period();
    srg_word_t per [3] = '{16'h0001, 16'h0003, 16'h0fff};
    int gap;
    reg_wr(8'h0e, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'h07, 16'h2000 | per[i]);
      frame_gap(gap);
      cmp(gap[15:0], 16'(per[i] * 16'h0002 * `SRG_HALF_TICKS));
    end
    $display("test frame_period done");
  endtask
  task automatic t_ref_sources();
    srg_word_t pc [3] = '{16'h0000, 16'h0080, 16'h0080};
    srg_word_t gc [3] = '{16'h0003, 16'h0003, 16'h2003};
    int t;
    int n;
    logic prev;
    reg_wr(8'h07, 16'h2003);
    count_toggles(250, t);
    cmp(t[15:0], 16'h00fa);
    for (int s = 0; s < 3; s++) begin
      reg_wr(8'h0e, pc[s]);
      reg_wr(8'h07, gc[s]);
      clk_run = 3'h1 << s;
      count_toggles(250, t);
      cmp({15'h0000, t >= 14 && t <= 18}, 16'h0001);
      clk_run = 3'h1 << ((s + 1) % 3);
      count_toggles(250, t);
      cmp(t[15:0], 16'h0000);
    end
    clk_run = 3'h0;
    // The rate alone cannot tell the edges apart, so check the pin level at each toggle
    reg_wr(8'h0e, 16'h0000);
    for (int e = 0; e < 2; e++) begin
      reg_wr(8'h07, (e == 1) ? 16'h4003 : 16'h0003);
      clk_run = 3'h1;
      cycles(10);
      n = 0;
      repeat (200) begin
        prev = bit_clk;
        cycles(1);
        if (bit_clk !== prev) begin
          n++;
          cmp({15'h0000, ext_clk}, 16'h0001 - e[15:0]);
        end
      end
      cmp({15'h0000, n > 10}, 16'h0001);
      clk_run = 3'h0;
    end
    $display("test ref_sources done");
  endtask
  task automatic t_tx_sync();
    int n;
    logic prev;
    reg_wr(8'h0e, 16'h0800);
    reg_wr(8'h07, 16'h2fff);
    cycles(20);
    cmp({14'h0000, tx_fs_oe, tx_fs}, 16'h0002);
    copy_watch(1'b0, n);
    cmp(n[15:0], 16'h0002);
    reg_wr(8'h0e, 16'h0808);
    cycles(4);
    cmp({14'h0000, tx_fs_oe, tx_fs}, 16'h0003);
    copy_watch(1'b1, n);
    cmp(n[15:0], 16'h0002);
    reg_wr(8'h0e, 16'h0800);
    reg_wr(8'h07, 16'h3003);
    // The frame count is already past the short period, so it must wrap before a pulse
    for (int i = 0; i < 9000 && gen_fs !== 1'b1; i++) cycles(1);
    prev = gen_fs;
    n = 0;
    repeat (40) begin
      cycles(1);
      cmp({15'h0000, tx_fs}, {15'h0000, prev});
      if (gen_fs === 1'b1) n++;
      prev = gen_fs;
    end
    cmp({15'h0000, n > 0}, 16'h0001);
    reg_wr(8'h0e, 16'h0000);
    cycles(4);
    cmp({15'h0000, tx_fs_oe}, 16'h0000);
    $display("test tx_sync done");
  endtask
  task automatic t_resync();
    int h;
    int f;
    reg_wr(8'h0e, 16'h0000);
    reg_wr(8'h07, 16'h8003);
    clk_run = 3'h1;
    count_fs(300, h);
    cmp(h[15:0], 16'h0000);
    sync_req = 1'b1;
    f = 0;
    // The receive start pulse comes once, ahead of the frame sync that it triggers
    for (h = 0; h < 100 && gen_fs !== 1'b1; h++) begin
      cycles(1);
      if (frame_start === 1'b1) f++;
    end
    sync_req = 1'b0;
    cmp({15'h0000, gen_fs}, 16'h0001);
    cmp(f[15:0], 16'h0001);
    for (h = 0; h < 100 && gen_fs === 1'b1; h++) cycles(1);
    count_fs(200, h);
    cmp(h[15:0], 16'h0000);
    clk_run = 3'h0;
    $display("test resync done");
  endtask
  task automatic t_clk_polarity();
    int n;
    int m;
    clk_run = 3'h6;
    for (int p = 0; p < 2; p++) begin
      reg_wr(8'h0e, p ? 16'h0003 : 16'h0000);
      n = 0;
      m = 0;
      repeat (300) begin
        cycles(1);
        if (shift_edge === 1'b1) m++;
        if (shift_edge === 1'b1) cmp({15'h0000, tx_clk}, 16'h0001 - p[15:0]);
        if (sample_edge === 1'b1) n++;
        if (sample_edge === 1'b1) cmp({15'h0000, rx_clk}, p[15:0]);
      end
      cmp({15'h0000, n > 0}, 16'h0001);
      cmp({15'h0000, m > 0}, 16'h0001);
    end
    clk_run = 3'h0;
    $display("test clk_polarity done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clk);
    #TD;
    rst_n = 1'b1;
    t_pin_status();
    t_frame_period();
    t_ref_sources();
    t_tx_sync();
    t_resync();
    t_clk_polarity();
    end_sim();
  end
  // Watchdog at about twice the expected run of some 30k cycles, inside the cycle budget
  initial begin
    #500_000;
    mismatches++;
    end_sim();
  end
endmodule
